// >>> logic/srwg_pkg.sv
// Purpose: shared constants and types of the supervisor reset and write guard
// Assumes: 100 MHz core clock
// Notes:   timeout figures are plain defaults, kept in microseconds
package srwg_pkg;

  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SYNC_STAGES      = 2;

  // reset timeout choices, selected by the two timeout-select bits
  localparam int unsigned TIMEOUT0_US      = 50;
  localparam int unsigned TIMEOUT1_US      = 100;
  localparam int unsigned TIMEOUT2_US      = 200;
  localparam int unsigned TIMEOUT3_US      = 400;
  localparam int unsigned TIMEOUT0_CYCLES  = TIMEOUT0_US * CLK_MHZ;
  localparam int unsigned TIMEOUT1_CYCLES  = TIMEOUT1_US * CLK_MHZ;
  localparam int unsigned TIMEOUT2_CYCLES  = TIMEOUT2_US * CLK_MHZ;
  localparam int unsigned TIMEOUT3_CYCLES  = TIMEOUT3_US * CLK_MHZ;
  localparam int unsigned TIMER_WIDTH      = 32;

  // control register layout
  localparam int unsigned CTRL_WIDTH       = 8;
  localparam int unsigned CTRL_SEL_LO_POS  = 0;
  localparam int unsigned CTRL_SEL_HI_POS  = 1;
  localparam int unsigned CTRL_LOCK_LO_POS = 2;
  localparam int unsigned CTRL_LOCK_HI_POS = 3;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [1:0]  LOCK_OPEN        = 2'h0;

  localparam int unsigned WIPER_WIDTH      = 6;
  localparam logic [5:0]  WIPER_RESET      = 6'h20;
  localparam int unsigned DATA_WIDTH       = 8;
  localparam int unsigned ADDR_WIDTH       = 8;

  typedef enum logic [1:0] {
    SRWG_TGT_ARRAY,
    SRWG_TGT_WIPER,
    SRWG_TGT_CONTROL,
    SRWG_TGT_NONE
  } srwg_target_type;

  typedef struct packed {
    logic                  valid;
    logic                  nonvolatile;
    srwg_target_type       target;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
  } srwg_wr_req_type;

  typedef struct packed {
    logic                  done;
    logic                  refused;
    logic                  array_write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
  } srwg_wr_rsp_type;

endpackage

// >>> logic/srwg_sync.sv
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
module srwg_sync #(
  parameter int unsigned WIDTH  = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          meta_q[i]   <= INIT[i];
          stable_q[i] <= INIT[i];
        end else begin
          meta_q[i]   <= async_in[i];
          stable_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = stable_q;

endmodule

// >>> logic/srwg_timer.sv
// Purpose: up counter that measures the reset timeout
// Assumes: limit is stable while the count runs
// Notes:   done is a level that holds until the next clear
`timescale 1ns/1ps
module srwg_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic             clear_in,
  input  wire logic [WIDTH-1:0] limit_in,
  output logic                  done_out
);

  logic [WIDTH-1:0] count_q;
  logic             done_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in || clear_in) begin
      count_q <= '0;
      done_q  <= 1'b0;
    end else if (!done_q) begin
      // limit of n gives done n cycles after clear drops
      if (count_q + WIDTH'(1) >= limit_in) begin
        done_q <= 1'b1;
      end
      count_q <= count_q + WIDTH'(1);
    end
  end

  assign done_out = done_q;

endmodule

// >>> logic/srwg_top.sv
// Purpose: supervisor reset generator, secondary fail indicator and write guard
// Assumes: comparators deliver clean logic levels; serial engine issues write requests
// Notes:   one clock, synchronous active-high reset models power-on
`timescale 1ns/1ps
module srwg_top #(
  parameter int unsigned TIMEOUT0_CYCLES = srwg_pkg::TIMEOUT0_CYCLES,
  parameter int unsigned TIMEOUT1_CYCLES = srwg_pkg::TIMEOUT1_CYCLES,
  parameter int unsigned TIMEOUT2_CYCLES = srwg_pkg::TIMEOUT2_CYCLES,
  parameter int unsigned TIMEOUT3_CYCLES = srwg_pkg::TIMEOUT3_CYCLES
) (
  input  wire logic                                 core_clk_in,
  input  wire logic                                 reset_in,
  // analog comparator results
  input  wire logic                                 supply_above_trip_in,
  input  wire logic                                 second_monitor_in,
  // board pins
  input  wire logic                                 manual_reset_in,
  input  wire logic                                 write_protect_in,
  input  wire logic                                 write_protect_floating_in,
  // serial data pin, open drain
  input  wire logic                                 sda_in,
  input  wire logic                                 sda_pull_low_in,
  output logic                                      sda_out,
  output logic                                      sda_oe_out,
  output logic                                      sda_rx_out,
  // write requests from the serial engine
  input  wire srwg_pkg::srwg_wr_req_type            wr_req_in,
  output srwg_pkg::srwg_wr_rsp_type                 wr_rsp_out,
  // state
  output logic                                      supply_reset_out,
  output logic                                      second_fail_out,
  output logic [srwg_pkg::CTRL_WIDTH-1:0]           control_register_out,
  output logic [srwg_pkg::WIPER_WIDTH-1:0]          potentiometer_zero_out,
  output logic [srwg_pkg::WIPER_WIDTH-1:0]          potentiometer_zero_nv_out,
  output logic                                      write_protect_active_out,
  output logic                                      lock_active_out,
  output logic                                      reset_timing_out
);

  typedef enum logic [1:0] {
    SRWG_RST_HOLD,
    SRWG_RST_TIMING,
    SRWG_RST_RUN
  } srwg_rst_state_type;

  localparam int unsigned TW = srwg_pkg::TIMER_WIDTH;

  // synchronised pins: supply ok, manual reset, protect, serial data
  logic [3:0] pins_async;
  logic [3:0] pins_sync;
  logic       supply_ok;
  logic       manual_hold;
  logic       protect_raw;
  logic       sda_seen;

  srwg_sync #(
    .WIDTH (4),
    .INIT  (4'h0)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    (pins_async),
    .sync_out    (pins_sync)
  );

  // floating pin is pulled down before it reaches the synchroniser
  assign pins_async = {sda_in,
                       write_protect_in & ~write_protect_floating_in,
                       manual_reset_in,
                       supply_above_trip_in};
  assign supply_ok   = pins_sync[0];
  assign manual_hold = pins_sync[1];
  assign protect_raw = pins_sync[2];
  assign sda_seen    = pins_sync[3];

  // receiver never gated by our own drive enable
  assign sda_rx_out = sda_seen;
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_pull_low_in;

  // direct wire: no sync or delay, so it can glitch with the comparator
  assign second_fail_out = second_monitor_in;

  // control register
  logic [srwg_pkg::CTRL_WIDTH-1:0] ctrl_q;
  logic [1:0]                      timeout_select;
  logic [1:0]                      lock_bits;
  logic                            timeout_select_lo;
  logic                            timeout_select_hi;

  assign timeout_select_lo = ctrl_q[srwg_pkg::CTRL_SEL_LO_POS];
  assign timeout_select_hi = ctrl_q[srwg_pkg::CTRL_SEL_HI_POS];
  assign timeout_select    = {timeout_select_hi, timeout_select_lo};
  assign lock_bits         = {ctrl_q[srwg_pkg::CTRL_LOCK_HI_POS], ctrl_q[srwg_pkg::CTRL_LOCK_LO_POS]};

  // write permission decode, shared by every target
  function automatic logic write_allowed(input logic protect,
                                         input logic [1:0] lock,
                                         input logic nonvolatile);
    logic ok;
    ok = 1'b1;
    if (protect && nonvolatile) begin
      ok = 1'b0;
    end
    if (protect && (lock != srwg_pkg::LOCK_OPEN)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // timeout lookup from the select bits
  function automatic logic [TW-1:0] timeout_cycles(input logic [1:0] sel);
    logic [TW-1:0] c;
    c = '0;
    case (sel)
      2'h0:    c = TW'(TIMEOUT0_CYCLES);
      2'h1:    c = TW'(TIMEOUT1_CYCLES);
      2'h2:    c = TW'(TIMEOUT2_CYCLES);
      default: c = TW'(TIMEOUT3_CYCLES);
    endcase
    return c;
  endfunction

  // reset sequencer
  srwg_rst_state_type rst_state_q;
  logic               reset_cause;
  logic               timer_clear;
  logic               timer_done;
  logic [TW-1:0]      timer_limit;

  assign reset_cause = ~supply_ok | manual_hold;
  assign timer_limit = timeout_cycles(timeout_select);
  // timer restarts whenever the cause is present or we are not timing
  assign timer_clear = reset_cause || (rst_state_q != SRWG_RST_TIMING);

  srwg_timer #(
    .WIDTH (TW)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .clear_in    (timer_clear),
    .limit_in    (timer_limit),
    .done_out    (timer_done)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rst_state_q <= SRWG_RST_HOLD;
    end else begin
      case (rst_state_q)
        SRWG_RST_HOLD: begin
          if (!reset_cause) begin
            rst_state_q <= SRWG_RST_TIMING;
          end
        end
        SRWG_RST_TIMING: begin
          if (reset_cause) begin
            rst_state_q <= SRWG_RST_HOLD;
          end else if (timer_done) begin
            rst_state_q <= SRWG_RST_RUN;
          end
        end
        SRWG_RST_RUN: begin
          if (reset_cause) begin
            rst_state_q <= SRWG_RST_HOLD;
          end
        end
        default: rst_state_q <= SRWG_RST_HOLD;
      endcase
    end
  end

  // cause drops into the output combinationally too, so assertion is immediate
  assign supply_reset_out = reset_cause || (rst_state_q != SRWG_RST_RUN);
  assign reset_timing_out = (rst_state_q == SRWG_RST_TIMING);

  // write guard
  logic                                 grant;
  logic [srwg_pkg::WIPER_WIDTH-1:0]     wiper_q;
  logic [srwg_pkg::WIPER_WIDTH-1:0]     wiper_nv_q;
  srwg_pkg::srwg_wr_rsp_type            rsp_q;

  assign grant = wr_req_in.valid
              && (wr_req_in.target != srwg_pkg::SRWG_TGT_NONE)
              && write_allowed(protect_raw, lock_bits, wr_req_in.nonvolatile);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_q <= srwg_pkg::CTRL_RESET;
    end else if (grant && (wr_req_in.target == srwg_pkg::SRWG_TGT_CONTROL)) begin
      ctrl_q <= wr_req_in.data;
    end
  end

  // volatile wiper; a nonvolatile write updates both copies
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wiper_q <= wiper_nv_q;
    end else if (grant && (wr_req_in.target == srwg_pkg::SRWG_TGT_WIPER)) begin
      wiper_q <= wr_req_in.data[srwg_pkg::WIPER_WIDTH-1:0];
    end
  end

  // nonvolatile copy survives reset, modelling the stored wiper position
  // power-on marker, set once by the first clock and never cleared by reset
  logic wiper_nv_init_q = 1'b0;
  always_ff @(posedge core_clk_in) begin
    if (!wiper_nv_init_q) begin
      wiper_nv_init_q <= 1'b1;
      wiper_nv_q      <= srwg_pkg::WIPER_RESET;
    end else if (!reset_in && grant && wr_req_in.nonvolatile
                 && (wr_req_in.target == srwg_pkg::SRWG_TGT_WIPER)) begin
      wiper_nv_q <= wr_req_in.data[srwg_pkg::WIPER_WIDTH-1:0];
    end
  end

  // one-cycle answers, registered
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q.done        <= grant;
      rsp_q.refused     <= wr_req_in.valid && !grant;
      rsp_q.array_write <= grant && (wr_req_in.target == srwg_pkg::SRWG_TGT_ARRAY);
      if (wr_req_in.valid) begin
        rsp_q.addr <= wr_req_in.addr;
        rsp_q.data <= wr_req_in.data;
      end
    end
  end

  assign wr_rsp_out                = rsp_q;
  assign control_register_out      = ctrl_q;
  assign potentiometer_zero_out    = wiper_q;
  assign potentiometer_zero_nv_out = wiper_nv_q;
  assign write_protect_active_out  = protect_raw;
  assign lock_active_out           = protect_raw && (lock_bits != srwg_pkg::LOCK_OPEN);

endmodule

// >>> sim/srwg_top_assertions.sv
// Purpose: port-level checker of the supervisor reset and write guard
// Assumes: pins settle through two sync flops before use
// Notes:   timeout window allows a few cycles of sync and state latency
`timescale 1ns/1ps
module srwg_top_assertions #(
  parameter int unsigned TIMEOUT0_CYCLES = srwg_pkg::TIMEOUT0_CYCLES,
  parameter int unsigned TIMEOUT1_CYCLES = srwg_pkg::TIMEOUT1_CYCLES,
  parameter int unsigned TIMEOUT2_CYCLES = srwg_pkg::TIMEOUT2_CYCLES,
  parameter int unsigned TIMEOUT3_CYCLES = srwg_pkg::TIMEOUT3_CYCLES
) (
  input wire logic                        core_clk_in,
  input wire logic                        reset_in,
  input wire logic                        supply_above_trip_in,
  input wire logic                        second_monitor_in,
  input wire logic                        manual_reset_in,
  input wire logic                        write_protect_floating_in,
  input wire logic                        sda_in,
  input wire logic                        sda_oe_out,
  input wire logic                        sda_rx_out,
  input wire srwg_pkg::srwg_wr_req_type   wr_req_in,
  input wire srwg_pkg::srwg_wr_rsp_type   wr_rsp_out,
  input wire logic                        supply_reset_out,
  input wire logic                        second_fail_out,
  input wire logic [7:0]                  control_register_out,
  input wire logic                        write_protect_active_out,
  input wire logic                        lock_active_out,
  input wire logic                        reset_timing_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  int unsigned cnt_q;
  int unsigned lim;
  // limit read live, so select must not change while timing
  assign lim = (control_register_out[1:0] == 2'h0) ? TIMEOUT0_CYCLES :
               (control_register_out[1:0] == 2'h1) ? TIMEOUT1_CYCLES :
               (control_register_out[1:0] == 2'h2) ? TIMEOUT2_CYCLES : TIMEOUT3_CYCLES;
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !reset_timing_out) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
  a_fail_follows:  assert property (second_fail_out == second_monitor_in)
    else $error("fail output differs from monitor");
  a_manual_forces: assert property (manual_reset_in [*3] |-> supply_reset_out)
    else $error("manual reset did not force reset");
  a_supply_low:    assert property (!supply_above_trip_in [*3] |-> supply_reset_out)
    else $error("low supply did not force reset");
  a_hold_timing:   assert property (reset_timing_out |-> supply_reset_out)
    else $error("reset released during timeout");
  a_timeout_len:   assert property ((!supply_reset_out && $past(reset_timing_out)) |->
                     (cnt_q + 1 >= lim && cnt_q <= lim + 2))
    else $error("timeout length wrong");
  a_nv_refused:    assert property ((wr_req_in.valid && wr_req_in.nonvolatile && write_protect_active_out)
                     |=> wr_rsp_out.refused && !wr_rsp_out.done)
    else $error("nonvolatile write not refused");
  a_lock_refused:  assert property ((wr_req_in.valid && lock_active_out) |=> wr_rsp_out.refused)
    else $error("locked write not refused");
  a_open_accept:   assert property ((wr_req_in.valid && !write_protect_active_out &&
                     wr_req_in.target != srwg_pkg::SRWG_TGT_NONE) |=> wr_rsp_out.done)
    else $error("open write not accepted");
  a_float_off:     assert property (write_protect_floating_in [*4] |-> !write_protect_active_out)
    else $error("floating pin enabled protection");
  a_rx_live:       assert property ((!$past(reset_in) && !$past(reset_in, 2) && sda_oe_out) |->
                     sda_rx_out == $past(sda_in, 2))
    else $error("receiver not observing line");
  c_manual: cover property (manual_reset_in [*3]);
  c_lock:   cover property (wr_req_in.valid && lock_active_out);
  c_timed:  cover property (!supply_reset_out && $past(reset_timing_out));
endmodule

// >>> sim/srwg_board.sv
// Purpose: board-side model of reset, protect pins and serial data line
// Assumes: data line has a pull-up
// Notes:   pins pass straight through, no delay
`timescale 1ns/1ps
module srwg_board (
  input  wire logic mr_req_in,
  input  wire logic wp_req_in,
  input  wire logic host_low_in,
  input  wire logic dut_oe_in,
  input  wire logic dut_sda_in,
  output logic      manual_reset_out,
  output logic      write_protect_out,
  output logic      sda_line_out
);
  assign manual_reset_out  = mr_req_in;
  assign write_protect_out = wp_req_in;
  // pull-up wins only when nobody drives low
  assign sda_line_out = !((dut_oe_in && !dut_sda_in) || host_low_in);
endmodule

// >>> sim/srwg_top_tb.sv
// Purpose: directed bench of the supervisor reset and write guard
// Assumes: short timeout parameters
// Notes:   inputs change by non-blocking assignment at rising edges or 1 ns after them
`timescale 1ns/1ps
module srwg_top_tb;
  localparam int unsigned T0 = 8, T1 = 16, T2 = 24, T3 = 32;
  logic clk, rst, sup_ok, mon2, mr_req, wp_req, wp_flt, host_low, pull_low;
  logic sda_line, man_rst, wp_pin, sda_o, sda_oe, sda_rx, sup_rst, fail2, wp_act, lock_act, timing;
  logic [7:0] ctrl;
  logic [5:0] pot, pot_nv;
  srwg_pkg::srwg_wr_req_type req;
  srwg_pkg::srwg_wr_rsp_type rsp;
  int err_count, n_checks, cyc, n;

  srwg_top #(.TIMEOUT0_CYCLES(T0), .TIMEOUT1_CYCLES(T1), .TIMEOUT2_CYCLES(T2), .TIMEOUT3_CYCLES(T3)) u_dut (
    .core_clk_in(clk), .reset_in(rst), .supply_above_trip_in(sup_ok), .second_monitor_in(mon2),
    .manual_reset_in(man_rst), .write_protect_in(wp_pin), .write_protect_floating_in(wp_flt),
    .sda_in(sda_line), .sda_pull_low_in(pull_low), .sda_out(sda_o), .sda_oe_out(sda_oe), .sda_rx_out(sda_rx),
    .wr_req_in(req), .wr_rsp_out(rsp), .supply_reset_out(sup_rst), .second_fail_out(fail2),
    .control_register_out(ctrl), .potentiometer_zero_out(pot), .potentiometer_zero_nv_out(pot_nv),
    .write_protect_active_out(wp_act), .lock_active_out(lock_act), .reset_timing_out(timing));
  srwg_board u_board (.mr_req_in(mr_req), .wp_req_in(wp_req), .host_low_in(host_low), .dut_oe_in(sda_oe),
    .dut_sda_in(sda_o), .manual_reset_out(man_rst), .write_protect_out(wp_pin), .sda_line_out(sda_line));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] t, input logic nv, input logic [7:0] d);
    @(posedge clk);
    req <= '{valid: 1'b1, nonvolatile: nv, target: srwg_pkg::srwg_target_type'(t), addr: 8'h00, data: d};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask
  // cycles until reset drops, bounded
  task automatic wait_rel();
    n = 0;
    while (sup_rst !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_powerup();
    chk(sup_rst, 1'b1);
    wait_rel();
    chk(n >= T0 && n <= T0 + 8, 1'b1);
  endtask
  task automatic t_guard();
    wr(2'h2, 1'b1, 8'h01);
    chk(rsp.done, 1'b1);
    chk(ctrl, 8'h01);
    wp_req <= 1'b1;
    tick(4);
    chk(wp_act, 1'b1);
    wr(2'h1, 1'b1, 8'h11);
    chk(rsp.refused, 1'b1);
    chk(pot_nv, 6'h20);
    wr(2'h1, 1'b0, 8'h12);
    chk(pot, 6'h12);
    wp_req <= 1'b0;
    tick(4);
    wr(2'h2, 1'b1, 8'h0D);
    chk(ctrl, 8'h0D);
    wp_req <= 1'b1;
    tick(4);
    chk(lock_act, 1'b1);
    wr(2'h1, 1'b0, 8'h13);
    chk(rsp.refused, 1'b1);
    chk(pot, 6'h12);
    wp_flt <= 1'b1;
    tick(4);
    chk(wp_act, 1'b0);
    wr(2'h1, 1'b1, 8'h14);
    chk(pot_nv, 6'h14);
    wr(2'h0, 1'b1, 8'h5A);
    chk(rsp.array_write, 1'b1);
    chk({rsp.addr, rsp.data}, 16'h005A);
    wr(2'h3, 1'b0, 8'h00);
    chk(rsp.refused, 1'b1);
    wp_flt <= 1'b0;
  endtask
  task automatic t_resets();
    mr_req <= 1'b1;
    tick(3);
    chk(sup_rst, 1'b1);
    mr_req <= 1'b0;
    wait_rel();
    chk(n >= T1 && n <= T1 + 8, 1'b1);
    sup_ok <= 1'b0;
    tick(3);
    chk(sup_rst, 1'b1);
    sup_ok <= 1'b1;
    wait_rel();
    chk(n >= T1 && n <= T1 + 8, 1'b1);
  endtask
  task automatic t_fail();
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      mon2 <= i[0];
      #1;
      chk(fail2, i[0]);
    end
  endtask
  task automatic t_sda();
    host_low <= 1'b1;
    tick(3);
    chk(sda_rx, 1'b0);
    host_low <= 1'b0;
    pull_low <= 1'b1;
    tick(3);
    chk(sda_oe, 1'b1);
    chk(sda_rx, 1'b0);
    pull_low <= 1'b0;
    tick(3);
    chk(sda_rx, 1'b1);
    chk(sda_o, 1'b0);
  endtask
  // the two upper timeout choices, reached by a manual reset each
  task automatic t_sel();
    wp_req <= 1'b0;
    tick(4);
    for (int s = 2; s <= 3; s++) begin
      wr(2'h2, 1'b1, 8'(s));
      mr_req <= 1'b1;
      tick(3);
      mr_req <= 1'b0;
      wait_rel();
      chk(n >= ((s == 2) ? T2 : T3) && n <= ((s == 2) ? T2 : T3) + 8, 1'b1);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    // whole run needs well under this
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {rst, sup_ok, mon2, mr_req, wp_req, wp_flt, host_low, pull_low} = 8'h80;
    sup_ok = 1'b1;
    req = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_powerup();
    t_guard();
    t_resets();
    t_fail();
    t_sda();
    t_sel();
    summarize();
  end
endmodule
bind srwg_top srwg_top_assertions #(.TIMEOUT0_CYCLES(TIMEOUT0_CYCLES), .TIMEOUT1_CYCLES(TIMEOUT1_CYCLES),
  .TIMEOUT2_CYCLES(TIMEOUT2_CYCLES), .TIMEOUT3_CYCLES(TIMEOUT3_CYCLES)) u_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .supply_above_trip_in(supply_above_trip_in),
  .second_monitor_in(second_monitor_in), .manual_reset_in(manual_reset_in),
  .write_protect_floating_in(write_protect_floating_in), .sda_in(sda_in), .sda_oe_out(sda_oe_out),
  .sda_rx_out(sda_rx_out), .wr_req_in(wr_req_in), .wr_rsp_out(wr_rsp_out), .supply_reset_out(supply_reset_out),
  .second_fail_out(second_fail_out), .control_register_out(control_register_out),
  .write_protect_active_out(write_protect_active_out), .lock_active_out(lock_active_out),
  .reset_timing_out(reset_timing_out));
